// ==== include/twras_defs.svh ====
// Purpose: Constants for the two-wire register access slave
// Assumes: Included by bare name
// Notes: Slave addresses are 7-bit, the register address reset value is 16-bit
`ifndef TWRAS_DEFS_SVH
`define TWRAS_DEFS_SVH
`define TWRAS_ADDR_DEFAULT 7'h36
`define TWRAS_ADDR_ALT 7'h37
`define TWRAS_DIR_BIT 0
`define TWRAS_REG_ADDR_RESET 16'h0000
`define TWRAS_BIT_LAST 3'h7
`endif

// ==== include/twras_pkg.sv ====
// Purpose: Types for the two-wire register access slave
// Assumes: Nothing
// Notes: States of the byte engine
package twras_pkg;
  typedef enum logic [3:0] {
    TWRAS_IDLE,
    TWRAS_DEV_BYTE,
    TWRAS_DEV_ACK,
    TWRAS_ADDR_HI,
    TWRAS_ADDR_HI_ACK,
    TWRAS_ADDR_LO,
    TWRAS_ADDR_LO_ACK,
    TWRAS_WR_DATA,
    TWRAS_WR_ACK,
    TWRAS_RD_DATA,
    TWRAS_RD_ACK
  } twras_state_type;
endpackage : twras_pkg

// ==== rtl/twras_edge.sv ====
// Purpose: Bus condition detector
// Assumes: Pins already synchronous to clk
// Notes: Registers previous levels, flags edges
`timescale 1ns/1ns
`default_nettype none
module twras_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_cond,
  output logic stop_cond
);
  logic scl_q;
  logic sda_q;
  logic next_scl_q;
  logic next_sda_q;

  always_comb begin
    next_scl_q = scl;
    next_sda_q = sda;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
    end
  end

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_cond = scl & scl_q & sda_q & ~sda;
  assign stop_cond = scl & scl_q & ~sda_q & sda;
endmodule : twras_edge
`default_nettype wire

// ==== rtl/twras_slave.sv ====
// Purpose: Two-wire serial register access slave
// Assumes: Pins synchronous to clk, master-driven clock only
// Notes: Register store is reached through reg_* ports
`timescale 1ns/1ns
`default_nettype none
`include "twras_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// - After a start the first byte holds a 7-bit address and a direction bit, 0 write, 1 read.
// - The slave acknowledges that byte only when its address bits match its own address.
// - A write carries a 16-bit register address in two bytes, each acknowledged.
// - The register address comes upper byte first, right after the write address byte.
// - Each following data byte is acknowledged and stored at the current register address.
// - Read data goes out a byte at a time while the master keeps acknowledging.
// - The register address steps by one after every data byte written or read, not after address bytes.
// - A no-acknowledge from the master ends read data driving.
// - A read without a fresh address load starts at the held register address.
// - Any number of write bytes are stored at rising addresses until a stop.
// - The register space is addressed by 16 bits through this interface only.
// - Data falling with clock high is a start, data rising with clock high is a stop.
// - The default address is used, or the alternate one when selected and enabled.
// - The serial clock is an input only and is never driven.
module twras_slave
  import twras_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic alternate_address_enable,
  input wire logic alternate_address_select,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // Conditions
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  twras_edge u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .scl(scl_in),
    .sda(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_cond(start_cond),
    .stop_cond(stop_cond)
  );

  function automatic logic [6:0] own_addr(input logic en, input logic sel);
    own_addr = (en && sel) ? `TWRAS_ADDR_ALT : `TWRAS_ADDR_DEFAULT;
  endfunction : own_addr

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  twras_state_type state;
  twras_state_type next_state;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [2:0] bitcnt;
  logic [2:0] next_bitcnt;
  logic [15:0] next_reg_addr;
  logic [7:0] next_reg_wdata;
  logic next_reg_wr;
  logic next_reg_rd;
  logic drive_low;
  logic next_drive_low;
  logic [7:0] rx_byte;

  assign rx_byte = {shreg[6:0], sda_in};
  // Open-drain: only ever pulls low; clock pin has no driver at all
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_reg_addr = reg_addr;
    next_reg_wdata = reg_wdata;
    next_reg_wr = 1'b0;
    next_reg_rd = 1'b0;
    next_drive_low = drive_low;
    if (stop_cond) begin
      next_state = TWRAS_IDLE;
      next_drive_low = 1'b0;
    end else if (start_cond) begin
      next_state = TWRAS_DEV_BYTE;
      next_bitcnt = 3'h0;
      next_drive_low = 1'b0;
    end else begin
      case (state)
        TWRAS_IDLE: begin
          next_drive_low = 1'b0;
        end
        TWRAS_DEV_BYTE, TWRAS_ADDR_HI, TWRAS_ADDR_LO, TWRAS_WR_DATA: begin
          if (scl_rise) begin
            next_shreg = rx_byte;
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == `TWRAS_BIT_LAST) begin
              case (state)
                TWRAS_DEV_BYTE: begin
                  if (rx_byte[7:1] == own_addr(alternate_address_enable,
                      alternate_address_select)) begin
                    next_state = TWRAS_DEV_ACK;
                  end else begin
                    next_state = TWRAS_IDLE;
                  end
                end
                TWRAS_ADDR_HI: begin
                  next_reg_addr = {rx_byte, reg_addr[7:0]};
                  next_state = TWRAS_ADDR_HI_ACK;
                end
                TWRAS_ADDR_LO: begin
                  next_reg_addr = {reg_addr[15:8], rx_byte};
                  next_state = TWRAS_ADDR_LO_ACK;
                end
                default: begin
                  next_reg_wdata = rx_byte;
                  next_reg_wr = 1'b1;
                  next_state = TWRAS_WR_ACK;
                end
              endcase
            end
          end
        end
        TWRAS_DEV_ACK, TWRAS_ADDR_HI_ACK, TWRAS_ADDR_LO_ACK, TWRAS_WR_ACK: begin
          if (scl_fall && !drive_low) begin
            next_drive_low = 1'b1;
          end else if (scl_fall && drive_low) begin
            next_drive_low = 1'b0;
            next_bitcnt = 3'h0;
            case (state)
              TWRAS_DEV_ACK: begin
                if (shreg[`TWRAS_DIR_BIT]) begin
                  next_state = TWRAS_RD_DATA;
                  next_shreg = reg_rdata;
                  next_drive_low = ~reg_rdata[7];
                end else begin
                  next_state = TWRAS_ADDR_HI;
                end
              end
              TWRAS_ADDR_HI_ACK: next_state = TWRAS_ADDR_LO;
              TWRAS_ADDR_LO_ACK: next_state = TWRAS_WR_DATA;
              default: begin
                next_reg_addr = reg_addr + 16'h0001;
                next_state = TWRAS_WR_DATA;
              end
            endcase
          end
        end
        TWRAS_RD_DATA: begin
          if (scl_fall) begin
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == `TWRAS_BIT_LAST) begin
              next_drive_low = 1'b0;
              next_reg_rd = 1'b1;
              next_reg_addr = reg_addr + 16'h0001;
              next_state = TWRAS_RD_ACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_drive_low = ~shreg[6];
            end
          end
        end
        TWRAS_RD_ACK: begin
          if (scl_rise && sda_in) begin
            next_state = TWRAS_IDLE;
          end else if (scl_fall) begin
            // Next byte loaded and MSB driven as the ack slot ends
            next_state = TWRAS_RD_DATA;
            next_shreg = reg_rdata;
            next_bitcnt = 3'h0;
            next_drive_low = ~reg_rdata[7];
          end
        end
        default: next_state = TWRAS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= TWRAS_IDLE;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      reg_addr <= `TWRAS_REG_ADDR_RESET;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      drive_low <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      reg_wr <= next_reg_wr;
      reg_rd <= next_reg_rd;
      drive_low <= next_drive_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_nack_idle;
    @(posedge clk) disable iff (!rst_n)
      (state == TWRAS_RD_ACK && scl_rise && sda_in && !stop_cond && !start_cond)
      |=> (state == TWRAS_IDLE) ##1 !sda_oe;
  endproperty
  a_nack_idle: assert property (p_nack_idle) else $error("Read not ended by nack");

  property p_wr_inc;
    @(posedge clk) disable iff (!rst_n)
      (state == TWRAS_WR_ACK && scl_fall && drive_low && !start_cond && !stop_cond)
      |=> reg_addr == $past(reg_addr) + 16'h0001;
  endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("Write address not stepped");

  property p_start_dev;
    @(posedge clk) disable iff (!rst_n)
      (start_cond && !stop_cond) |=> state == TWRAS_DEV_BYTE && !sda_oe;
  endproperty
  a_start_dev: assert property (p_start_dev) else $error("Start not honoured");

  property p_idle_quiet;
    @(posedge clk) disable iff (!rst_n)
      (state == TWRAS_IDLE) |-> !sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Driving while ignored");

  property p_mismatch;
    @(posedge clk) disable iff (!rst_n)
      (state == TWRAS_DEV_BYTE && scl_rise && bitcnt == 3'h7 && !start_cond && !stop_cond &&
       rx_byte[7:1] != own_addr(alternate_address_enable, alternate_address_select))
      |=> state == TWRAS_IDLE;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("Foreign address taken");

  property p_hi_first;
    @(posedge clk) disable iff (!rst_n)
      (state == TWRAS_ADDR_HI && scl_rise && bitcnt == 3'h7 && !start_cond && !stop_cond)
      |=> reg_addr[15:8] == $past(rx_byte);
  endproperty
  a_hi_first: assert property (p_hi_first) else $error("Upper address byte misplaced");

  property p_wr_strobe;
    @(posedge clk) disable iff (!rst_n)
      reg_wr |-> state == TWRAS_WR_ACK ##1 !reg_wr;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("Write strobe misplaced");

  property p_rd_inc;
    @(posedge clk) disable iff (!rst_n)
      reg_rd |-> reg_addr == $past(reg_addr) + 16'h0001;
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("Read address not stepped");

  c_write: cover property (@(posedge clk) disable iff (!rst_n) reg_wr);
  c_read: cover property (@(posedge clk) disable iff (!rst_n) reg_rd);
  c_seq_read: cover property (@(posedge clk) disable iff (!rst_n)
    state == TWRAS_RD_ACK ##1 state == TWRAS_RD_DATA);
  c_mismatch: cover property (@(posedge clk) disable iff (!rst_n)
    state == TWRAS_DEV_BYTE ##1 state == TWRAS_IDLE);
endmodule : twras_slave
`default_nettype wire

// ==== verification/twras_master_model.sv ====
// Purpose: Behavioural bus master for the register access slave
// Assumes: Tasks are called just after a clk rising edge
// Notes: Drives clock and pulls data low only; line resolved outside
`timescale 1ns/1ns
`default_nettype none
module twras_master_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  // Start or restart: data falls while clock high
  task automatic start_bit();
    sda_low <= 1'b0;
    hold(3);
    scl <= 1'b1;
    hold(3);
    sda_low <= 1'b1;
    hold(3);
    scl <= 1'b0;
    hold(1);
  endtask : start_bit
  // Stop: data rises while clock high
  task automatic stop_bit();
    sda_low <= 1'b1;
    hold(3);
    scl <= 1'b1;
    hold(3);
    sda_low <= 1'b0;
    hold(4);
  endtask : stop_bit
  // One bit, data changes only while clock low
  task automatic bit_cycle(input logic b, output logic s);
    sda_low <= ~b;
    hold(3);
    scl <= 1'b1;
    hold(3);
    s = sda_line;
    hold(2);
    scl <= 1'b0;
    hold(1);
  endtask : bit_cycle
  // Byte out MSB first, then release for the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask : send_byte
  // Byte in, then ack to continue or no-ack to end
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, d[i]);
    end
    bit_cycle(~more, s);
  endtask : recv_byte
endmodule : twras_master_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the register access slave
// Assumes: Master model drives the bus, bench holds the register store
// Notes: Store indexed by low address byte
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import twras_pkg::*;
  logic clk, rst_n, alt_en, alt_sel, scl, m_low, sda, sda_out, sda_oe, reg_wr, reg_rd, ack;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, rdata, d;
  logic [7:0] mem [0:255];
  int fail_count = 0;
  int n_checks = 0;
  int wr_count = 0;
  int rd_count = 0;
  assign sda = (m_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  assign rdata = mem[reg_addr[7:0]];
  twras_master_model m_u (.clk(clk), .sda_line(sda), .scl(scl), .sda_low(m_low));
  twras_slave dut_u (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .alternate_address_enable(alt_en), .alternate_address_select(alt_sel),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr[7:0]] <= reg_wdata;
      wr_count <= wr_count + 1;
    end
    if (reg_rd === 1'b1) begin
      rd_count <= rd_count + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic set_addr(input logic [15:0] a);
    m_u.start_bit();
    m_u.send_byte(8'h6c, ack);
    chk(16'(ack), 16'h0001, "write dev ack");
    m_u.send_byte(a[15:8], ack);
    chk(16'(ack), 16'h0001, "addr hi ack");
    m_u.send_byte(a[7:0], ack);
    chk(16'(ack), 16'h0001, "addr lo ack");
  endtask : set_addr
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_write();
    set_addr(16'h0110);
    m_u.send_byte(8'ha1, ack);
    chk(16'(ack), 16'h0001, "data ack");
    m_u.send_byte(8'hb2, ack);
    chk(16'(ack), 16'h0001, "second data ack");
    m_u.send_byte(8'hc3, ack);
    chk(16'(ack), 16'h0001, "third data ack");
    m_u.stop_bit();
    chk({8'h00, mem[8'h10]}, 16'h00a1, "byte 0 stored");
    chk({8'h00, mem[8'h11]}, 16'h00b2, "byte 1 stored");
    chk({8'h00, mem[8'h12]}, 16'h00c3, "byte 2 stored");
    chk(reg_addr, 16'h0113, "addr after write");
    chk(16'(wr_count), 16'h0003, "write count");
    $display("Test write done");
  endtask : t_write
  task automatic t_read_random();
    set_addr(16'h0110);
    m_u.start_bit();
    m_u.send_byte(8'h6d, ack);
    chk(16'(ack), 16'h0001, "read dev ack");
    m_u.recv_byte(1'b1, d);
    chk({8'h00, d}, 16'h00a1, "read byte 0");
    m_u.recv_byte(1'b0, d);
    chk({8'h00, d}, 16'h00b2, "read byte 1");
    m_u.stop_bit();
    chk(16'(sda), 16'h0001, "line released");
    chk(reg_addr, 16'h0112, "addr after read");
    chk(16'(rd_count), 16'h0002, "read strobes");
    chk(16'(wr_count), 16'h0003, "dummy write stores nothing");
    $display("Test random read done");
  endtask : t_read_random
  task automatic t_read_current();
    m_u.start_bit();
    m_u.send_byte(8'h6d, ack);
    chk(16'(ack), 16'h0001, "current read ack");
    m_u.recv_byte(1'b0, d);
    chk({8'h00, d}, 16'h00c3, "current read data");
    m_u.stop_bit();
    chk(reg_addr, 16'h0113, "addr after current read");
    chk(16'(rd_count), 16'h0003, "current read strobe");
    $display("Test current read done");
  endtask : t_read_current
  task automatic t_addr_sel();
    logic [7:0] dev [4] = '{8'h6c, 8'h6e, 8'h6c, 8'h6e};
    logic [3:0] en = 4'b0011;
    logic [3:0] ok = 4'b0110;
    m_u.start_bit();
    m_u.send_byte(8'h70, ack);
    chk(16'(ack), 16'h0000, "foreign addr");
    m_u.send_byte(8'h6c, ack);
    chk(16'(ack), 16'h0000, "ignored until start");
    m_u.stop_bit();
    chk(16'(wr_count), 16'h0003, "no store after mismatch");
    alt_sel <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      alt_en <= en[i];
      m_u.start_bit();
      m_u.send_byte(dev[i], ack);
      chk(16'(ack), 16'(ok[i]), "address select");
      m_u.stop_bit();
    end
    $display("Test address select done");
  endtask : t_addr_sel
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n <= 1'b0;
    alt_en <= 1'b0;
    alt_sel <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(16'(sda_oe), 16'h0000, "released after reset");
    chk(reg_addr, 16'h0000, "addr after reset");
    t_write();
    t_read_random();
    t_read_current();
    t_addr_sel();
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    $display("MISMATCH t=%0t run did not finish", $time);
    close_out();
  end
endmodule : testbench
`default_nettype wire
